// File: rtl/osf_fault_logic.sv
// Fault detection, latch-off and serial status logic of an octal low-side switch
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - True status ready 25 to 100 us
// - Report four fault types, per output
// - Overvoltage forces all outputs off
// - Over-temperature turns off its output only
// - Thermally off output reads as off
// - After cooling, re-enable only on write
// - Overvoltage keeps outputs off until rewritten
// - First word after overvoltage reads all ones
// - No logic supply overvoltage detection
// - Open load checked only when commanded off
// - Open load when drain below threshold
// - Select rise starts fault delay timer
// - Open load flag clears by itself
// - Early short shuts down after delay
// - Late short shuts down within 20 us
// - Protect disabled: current limit, no shutdown
// - Disable input affects only overcurrent
// - Thermal limit latches only faulted output
// - Shorted output stays off until write
// - Status high when off unless open load, MSB is output 7
module osf_fault_logic
  import osf_pkg::*;
#(
  parameter int FDLY_CYC = OSF_FDLY_CYC            // Fault delay, shortenable
) (
  input wire logic hclk,                           // System clock
  input wire logic hresetn,                        // Async reset, active low
  input wire logic hsel,                           // AHB select
  input wire logic [31:0] haddr,                   // AHB address
  input wire logic [1:0] htrans,                   // AHB transfer type
  input wire logic hwrite,                         // AHB write
  input wire logic [2:0] hsize,                    // AHB size
  input wire logic [31:0] hwdata,                  // AHB write data
  input wire logic hready,                         // AHB bus ready
  output logic [31:0] hrdata,                      // AHB read data
  output logic hreadyout,                          // AHB slave ready
  output logic hresp,                              // AHB response
  input wire logic chip_select_low,                // Serial select, active low
  input wire logic sclk,                           // Serial clock
  input wire logic si,                             // Serial data in
  output logic so,                                 // Serial data out
  output logic so_oe,                              // Serial out enable
  input wire logic short_protect_disable,          // Pin: keep on in current limit
  input wire osf_sense_t sense,                    // Analog comparator outputs
  output logic [7:0] out_on,                       // Gate drive per output
  output logic [7:0] cur_limit                     // Current limited mode
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_s1_q;                            // First stage, pins
  logic [2:0] pin_s2_q;                            // Second stage, pins
  logic pin_s3_q;                                  // Previous sclk for edges
  logic cs_prev_q;                                 // Previous select
  osf_sense_t sns_s1_q;                            // First stage, sense
  osf_sense_t sns_s2_q;                            // Second stage, sense
  logic spd_s1_q;                                  // First stage, disable pin
  logic spd_s2_q;                                  // Second stage, disable pin

  // Two flops on the serial pins, sense inputs and disable pin; only stage two is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 1'b0;
      cs_prev_q <= 1'b1;
      sns_s1_q <= '0;
      sns_s2_q <= '0;
      spd_s1_q <= 1'b0;
      spd_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= {chip_select_low, sclk, si};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q[1];
      cs_prev_q <= pin_s2_q[2];
      sns_s1_q <= sense;
      sns_s2_q <= sns_s1_q;
      spd_s1_q <= short_protect_disable;
      spd_s2_q <= spd_s1_q;
    end
  end

  logic cs_n;                                      // Synced select
  logic sclk_rise;                                 // Serial clock rising
  logic sclk_fall;                                 // Serial clock falling
  logic cs_fall;                                   // Frame start
  logic cs_rise;                                   // Frame end, latch command
  assign cs_n = pin_s2_q[2];
  assign sclk_rise = pin_s2_q[1] & ~pin_s3_q & ~cs_n;
  assign sclk_fall = ~pin_s2_q[1] & pin_s3_q & ~cs_n;
  assign cs_fall = cs_prev_q & ~cs_n;
  assign cs_rise = ~cs_prev_q & cs_n;

  // ------------------------------------------------------------
  // Software control register
  // ------------------------------------------------------------
  logic spd_sw_q;                                  // Software disable request
  logic spd_eff;                                   // Effective protect disable
  assign spd_eff = spd_s2_q | spd_sw_q;

  // ------------------------------------------------------------
  // Serial frame state machine and shifter
  // ------------------------------------------------------------
  osf_state_t st_q, st_d;                          // Frame state
  logic [7:0] sh_q, sh_d;                          // Shift register
  logic [7:0] cmd_q, cmd_d;                        // Latched command, low = on
  logic [7:0] stat_word;                           // Present status, loaded into shifter at frame start
  logic so_q, so_d;                                // Serial out flop
  logic ov_lat_q, ov_lat_d;                        // Overvoltage latched
  logic [7:0] ot_lat_q, ot_lat_d;                  // Thermal latched off
  logic [7:0] sc_lat_q, sc_lat_d;                  // Short latched off
  logic [7:0] drv;                                 // Present gate drive
  logic dly_done;                                  // Comparators enabled

  // Status: high for off, low for open load once the delay is done, forced all ones after overvoltage
  always_comb begin
    stat_word = ~drv;
    for (int i = 0; i < OSF_NCH; i++) begin
      if (cmd_q[i] && dly_done && sns_s2_q.drain_low[i]) begin
        stat_word[i] = 1'b0;
      end
    end
    if (ov_lat_q) begin
      stat_word = OSF_ALL_OFF;
    end
  end

  // Frame sequencing; commands only take effect at select rising
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    so_d = so_q;
    case (st_q)
      OSF_IDLE: begin
        if (cs_fall) begin
          sh_d = stat_word;
          so_d = stat_word[OSF_NCH-1];
          st_d = OSF_SHIFT;
        end
      end
      OSF_SHIFT: begin
        if (cs_rise) begin
          st_d = OSF_DONE;
        end else if (sclk_rise) begin
          so_d = sh_q[OSF_NCH-1];
        end else if (sclk_fall) begin
          sh_d = {sh_q[OSF_NCH-2:0], pin_s2_q[0]};
        end
      end
      OSF_DONE: begin
        cmd_d = sh_q;
        st_d = OSF_IDLE;
      end
      default: st_d = OSF_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= OSF_IDLE;
      sh_q <= '0;
      cmd_q <= OSF_ALL_OFF;
      so_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      so_q <= so_d;
    end
  end

  assign so = so_q;
  assign so_oe = ~cs_n;

  // ------------------------------------------------------------
  // Fault delay timer
  // ------------------------------------------------------------
  logic [$clog2(FDLY_CYC+1):0] dly_q, dly_d;       // Cycles left
  assign dly_done = (dly_q == '0);

  // Restarted by each select rising, counts down to zero
  always_comb begin
    dly_d = dly_q;
    if (cs_rise) begin
      dly_d = ($bits(dly_q))'(FDLY_CYC);
    end else if (!dly_done) begin
      dly_d = dly_q - 1'b1;
    end
  end

  // Starts running so status is valid only after the delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_q <= ($bits(dly_q))'(FDLY_CYC);
    end else begin
      dly_q <= dly_d;
    end
  end

  // ------------------------------------------------------------
  // Protection latches
  // ------------------------------------------------------------
  // Thermal acts without the timer; short waits for it
  always_comb begin
    ov_lat_d = ov_lat_q;
    ot_lat_d = ot_lat_q;
    sc_lat_d = sc_lat_q;
    if (st_q == OSF_DONE) begin
      ot_lat_d = '0;
      sc_lat_d = '0;
      if (!sns_s2_q.ov) begin
        ov_lat_d = 1'b0;
      end
    end
    if (sns_s2_q.ov) begin
      ov_lat_d = 1'b1;
    end
    ot_lat_d = ot_lat_d | sns_s2_q.otemp;
    if (dly_done && !spd_eff) begin
      sc_lat_d = sc_lat_d | (sns_s2_q.ocur & ~cmd_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_lat_q <= 1'b0;
      ot_lat_q <= '0;
      sc_lat_q <= '0;
    end else begin
      ov_lat_q <= ov_lat_d;
      ot_lat_q <= ot_lat_d;
      sc_lat_q <= sc_lat_d;
    end
  end

  // Drive: commanded on and no latch; overvoltage kills all
  assign drv = ov_lat_q ? '0 : (~cmd_q & ~ot_lat_q & ~sc_lat_q);
  assign out_on = drv;
  assign cur_limit = drv & sns_s2_q.ocur & {OSF_NCH{spd_eff}};

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  logic ap_wr_q, ap_wr_d;                          // Pending write
  logic ap_rd_q, ap_rd_d;                          // Pending read
  logic [7:0] ap_adr_q, ap_adr_d;                  // Latched address
  logic [31:0] rd_q, rd_d;                         // Read data
  logic spd_sw_d;                                  // Next control bit
  logic acc;                                       // Valid word access

  assign acc = hsel & hready & (htrans == OSF_HTRANS_NONSEQ) & (hsize == OSF_HSIZE_WORD);

  // Address phase capture, data phase write, read mux
  always_comb begin
    ap_wr_d = acc & hwrite;
    ap_rd_d = acc & ~hwrite;
    ap_adr_d = haddr[OSF_AW-1:0];
    spd_sw_d = spd_sw_q;
    rd_d = rd_q;
    if (ap_wr_q && ap_adr_q == OSF_CTRL_OFS) begin
      spd_sw_d = hwdata[OSF_CTRL_SPD];
    end
    if (acc && !hwrite) begin
      case (haddr[OSF_AW-1:0])
        OSF_CTRL_OFS: rd_d = {31'h0, spd_sw_q};
        OSF_STAT_OFS: rd_d = {16'h0, cmd_q, drv};
        OSF_FLT_OFS: rd_d = {6'h0, ~dly_done, ov_lat_q, ot_lat_q, sc_lat_q, stat_word};
        OSF_SENS_OFS: rd_d = {7'h0, sns_s2_q};
        default: rd_d = 32'h0;                     // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_adr_q <= '0;
      spd_sw_q <= 1'b0;
      rd_q <= '0;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_rd_q <= ap_rd_d;
      ap_adr_q <= ap_adr_d;
      spd_sw_q <= spd_sw_d;
      rd_q <= rd_d;
    end
  end

  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ov_all_off;
    @(posedge hclk) disable iff (!hresetn) sns_s2_q.ov |=> (out_on == 8'h00);
  endproperty
  a_ov_all_off: assert property (p_ov_all_off) else $error("drive on during overvoltage");

  property p_ot_off;
    @(posedge hclk) disable iff (!hresetn) (sns_s2_q.otemp != 8'h00) |=> ((out_on & $past(sns_s2_q.otemp)) == 8'h00);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("thermal output still on");

  property p_ot_stays;
    @(posedge hclk) disable iff (!hresetn) (ot_lat_q != 8'h00 && st_q != OSF_DONE)
      |=> ((ot_lat_q & $past(ot_lat_q)) == $past(ot_lat_q));
  endproperty
  a_ot_stays: assert property (p_ot_stays) else $error("thermal latch cleared without write");

  property p_ov_ff;
    @(posedge hclk) disable iff (!hresetn) (ov_lat_q && st_q == OSF_IDLE && cs_fall) |=> (sh_q == 8'hff);
  endproperty
  a_ov_ff: assert property (p_ov_ff) else $error("status not all ones after overvoltage");

  property p_dly_start;
    @(posedge hclk) disable iff (!hresetn) cs_rise |=> !dly_done [*8];
  endproperty
  a_dly_start: assert property (p_dly_start) else $error("delay not started on select rise");

  property p_no_early_short;
    @(posedge hclk) disable iff (!hresetn) (!dly_done && st_q != OSF_DONE) |=> ((sc_lat_q & ~$past(sc_lat_q)) == 8'h00);
  endproperty
  a_no_early_short: assert property (p_no_early_short) else $error("short latched inside delay");

  property p_late_short;
    @(posedge hclk) disable iff (!hresetn) (dly_done && !spd_eff && ((sns_s2_q.ocur & ~cmd_q) != 8'h00))
      |=> ((out_on & $past(sns_s2_q.ocur) & ~$past(cmd_q)) == 8'h00);
  endproperty
  a_late_short: assert property (p_late_short) else $error("late short not shut down");

  property p_spd_no_latch;
    @(posedge hclk) disable iff (!hresetn) (spd_eff && st_q != OSF_DONE) |=> ((sc_lat_q & ~$past(sc_lat_q)) == 8'h00);
  endproperty
  a_spd_no_latch: assert property (p_spd_no_latch) else $error("short latched while disabled");

  property p_off_reads_high;
    @(posedge hclk) disable iff (!hresetn) !ov_lat_q
      |-> (((stat_word | drv | (cmd_q & sns_s2_q.drain_low)) == 8'hff) && ((stat_word & drv) == 8'h00));
  endproperty
  a_off_reads_high: assert property (p_off_reads_high) else $error("off output reads low");

endmodule : osf_fault_logic
`default_nettype wire

// File: rtl/osf_pkg.sv
// Package of constants and types for the octal switch fault logic
package osf_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int OSF_NCH = 8;                       // Output channels
  localparam int OSF_AW = 8;                        // Bus address bits decoded

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int OSF_CLK_MHZ = 40;                  // hclk rate in MHz
  localparam int OSF_FDLY_US = 50;                  // Fault delay, inside 25..100 us
  localparam int OSF_FDLY_CYC = OSF_FDLY_US * OSF_CLK_MHZ; // Delay in cycles
  localparam int OSF_SHRT_US = 20;                  // Short shutdown bound
  localparam int OSF_SHRT_CYC = OSF_SHRT_US * OSF_CLK_MHZ; // Longest, rounded down
  localparam int OSF_CLIM_US = 5;                   // Current limit entry, least
  localparam int OSF_CLIM_CYC = OSF_CLIM_US * OSF_CLK_MHZ; // Least, rounded up

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OSF_CTRL_OFS = 8'h00;      // Control bits
  localparam logic [7:0] OSF_STAT_OFS = 8'h04;      // Output drive state
  localparam logic [7:0] OSF_FLT_OFS = 8'h08;       // Fault summary
  localparam logic [7:0] OSF_SENS_OFS = 8'h0c;      // Fault sense inputs

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int OSF_CTRL_SPD = 0;                  // Short protect disable bit
  localparam int OSF_FLT_OV = 24;                   // Overvoltage latch bit
  localparam int OSF_FLT_DLY = 25;                  // Delay timer running bit
  localparam logic [7:0] OSF_ALL_OFF = 8'hff;       // Command word all off
  localparam logic [1:0] OSF_HTRANS_NONSEQ = 2'h2;  // AHB NONSEQ code
  localparam logic [2:0] OSF_HSIZE_WORD = 3'h2;     // AHB word size

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] otemp;                              // Over-temperature sense
    logic [7:0] drain_low;                          // Drain below drain_threshold
    logic [7:0] ocur;                               // Overcurrent comparator
    logic ov;                                       // load_supply overvoltage
  } osf_sense_t;

  typedef enum logic [2:0] {
    OSF_IDLE = 3'b001,                              // Select high, no frame
    OSF_SHIFT = 3'b010,                             // Shifting a frame
    OSF_DONE = 3'b100                               // Frame ended, update
  } osf_state_t;

endpackage : osf_pkg

// File: tb/osf_spi_master.sv
// Serial controller model that drives the select, link clock and command line
`timescale 1ns/1ps
`default_nettype none
module osf_spi_master (
  output logic chip_select_low,  // Select, active low
  output logic sclk,             // Link clock, still outside frames
  output logic si,               // Command bits to the switch
  input wire logic so,           // Status bits from the switch
  input wire logic so_oe         // Status line driven
);
  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    si = 1'b1;
  end

  // ------------------------------------------------------------
  // One frame of 8 bits, first bit is output 7
  // ------------------------------------------------------------
  // Command bit changes with each rise; status is taken at each fall, settled since the rise
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] stat);
    int i;
    #37 chip_select_low = 1'b0;
    #200;
    for (i = 7; i >= 0; i--) begin
      #100 sclk = 1'b1;
      si = cmd[i];                   // Stable well before the fall that takes it
      #100 sclk = 1'b0;
      stat[i] = so_oe ? so : 1'bz;   // Undriven line never matches
    end
    #100 chip_select_low = 1'b1;
    si = ~si;                        // Inverted: no stale value left behind
    #200;
  endtask : xfer
endmodule : osf_spi_master
`default_nettype wire

// File: tb/test_octal_switch_fault_logic.sv
// Self-checking bench of the octal switch fault logic
`timescale 1ns/1ps
`default_nettype none
module test_octal_switch_fault_logic
  import osf_pkg::*;
;
  localparam int FDLY = 200;         // Shortened fault delay, in cycles
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, so, so_oe, spd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] out_on, cur_limit;
  logic csl, sclk, si;
  osf_sense_t sense;                 // Comparator levels from the bench
  int fails, n_compared;

  // ------------------------------------------------------------
  // Design, far side and clock
  // ------------------------------------------------------------
  osf_fault_logic #(.FDLY_CYC(FDLY)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chip_select_low(csl), .sclk(sclk), .si(si), .so(so),
    .so_oe(so_oe), .short_protect_disable(spd), .sense(sense), .out_on(out_on), .cur_limit(cur_limit));
  osf_spi_master m_u (.chip_select_low(csl), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;         // 40 MHz

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Bounded wait for one output to reach a level, then judge it
  task automatic wait_on(input int ch, input logic v, input int n);
    int k;
    for (k = 0; k < n && out_on[ch] !== v; k++) @(posedge hclk);
    chk({31'h0, out_on[ch]}, {31'h0, v});
  endtask : wait_on
  task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] st;
    m_u.xfer(cmd, st);
    chk({24'h0, st}, {24'h0, exp});
  endtask : frame
  // Single word transfer; address phase held until ready is seen
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= OSF_HTRANS_NONSEQ;
    hsize <= OSF_HSIZE_WORD;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_start;
    frame(8'h5a, OSF_ALL_OFF);
    chk({24'h0, out_on}, 32'ha5);
    frame(8'h5a, 8'h5a);
    cyc(FDLY + 20);
    frame(8'h5a, 8'h5a);
  endtask : t_start
  task automatic t_otemp;
    cyc(1);
    sense.otemp[2] <= 1'b1;
    wait_on(2, 1'b0, 8);
    chk({24'h0, out_on}, 32'ha1);
    sense.otemp[2] <= 1'b0;
    cyc(20);
    chk({24'h0, out_on}, 32'ha1);
    frame(8'h5a, 8'h5e);
    chk({24'h0, out_on}, 32'ha5);
  endtask : t_otemp
  task automatic t_ov;
    cyc(1);
    sense.ov <= 1'b1;
    wait_on(0, 1'b0, 8);
    chk({24'h0, out_on}, 32'h0);
    sense.ov <= 1'b0;
    cyc(20);
    chk({24'h0, out_on}, 32'h0);
    frame(8'h08, 8'hff);
    chk({24'h0, out_on}, 32'hf7);
  endtask : t_ov
  task automatic t_short;
    cyc(FDLY + 20);
    sense.ocur[4] <= 1'b1;
    wait_on(4, 1'b0, OSF_SHRT_CYC);
    sense.ocur[3] <= 1'b1;
    sense.ocur[4] <= 1'b0;
    frame(8'h00, 8'h18);
    chk({31'h0, out_on[3]}, 32'h1);
    cyc(FDLY / 2);
    chk({31'h0, out_on[3]}, 32'h1);
    wait_on(3, 1'b0, FDLY);
    sense.ocur[3] <= 1'b0;
    cyc(20);
    chk({24'h0, out_on}, 32'hf7);
    frame(8'h00, 8'h08);
    chk({24'h0, out_on}, 32'hff);
  endtask : t_short
  task automatic t_limit;
    cyc(FDLY + 20);
    spd <= 1'b1;
    sense.ocur[1] <= 1'b1;
    cyc(2 * OSF_CLIM_CYC + 8);
    chk({24'h0, out_on}, 32'hff);
    chk({24'h0, cur_limit}, 32'h02);
    sense.otemp[1] <= 1'b1;
    wait_on(1, 1'b0, 8);
    sense.otemp[1] <= 1'b0;
    sense.ocur[1] <= 1'b0;
    spd <= 1'b0;
    frame(8'h00, 8'h02);
  endtask : t_limit
  task automatic t_open;
    frame(8'hff, 8'h00);
    cyc(1);
    sense.drain_low[5] <= 1'b1;
    frame(8'hff, 8'hff);
    cyc(FDLY + 20);
    frame(8'hff, 8'hdf);
    cyc(1);
    ahb(1'b0, {24'h0, OSF_SENS_OFS}, 32'h0, rd);
    chk(rd, {7'h0, sense});
    sense.drain_low[5] <= 1'b0;
    cyc(FDLY + 20);
    frame(8'hff, 8'hff);
  endtask : t_open
  task automatic t_regs;
    cyc(1);
    ahb(1'b0, {24'h0, OSF_CTRL_OFS}, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, {24'h0, OSF_CTRL_OFS}, 32'h1, rd);
    ahb(1'b0, {24'h0, OSF_CTRL_OFS}, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b1, 32'h10, 32'hffffffff, rd);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : t_regs

  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // Whole run needs about 70 us; seven times that means a hang
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
  initial begin
    fails = 0;
    n_compared = 0;
    hresetn = 1'b0;
    {hsel, hwrite, spd} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    sense = '0;
    cyc(3);
    hresetn <= 1'b1;
    cyc(1);
    t_start();
    t_otemp();
    t_ov();
    t_short();
    t_limit();
    t_open();
    t_regs();
    tally_and_finish();
  end
endmodule : test_octal_switch_fault_logic
`default_nettype wire
